// >>> ppm_pkg.sv
// Shared types and constants for the parallel port mode control block.
// Assumes a single 200 MHz clock and a plain strobe-based register port.
package ppm_pkg;

  // Register port and instruction cycle timing.
  localparam int unsigned REG_AW      = 6;
  localparam int unsigned CLK_NS      = 5;
  localparam int unsigned TCY_NS      = 10;
  localparam int unsigned CYC_PER_TCY = (TCY_NS + CLK_NS - 1) / CLK_NS;

  // Register byte addresses.
  localparam logic [5:0] OFS_CTRL  = 6'h00;
  localparam logic [5:0] OFS_ADDR  = 6'h04;
  localparam logic [5:0] OFS_DATA  = 6'h08;
  localparam logic [5:0] OFS_STAT  = 6'h0C;
  localparam logic [5:0] OFS_MASK  = 6'h10;
  localparam logic [5:0] OFS_SBUF0 = 6'h14;
  localparam logic [5:0] OFS_SBUF3 = 6'h20;

  // Sizes, reset values and status bit positions.
  localparam int unsigned PA_W      = 11;
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [1:0]  LAST_BUF  = 2'h3;
  localparam int unsigned ST_W      = 2;
  localparam int unsigned ST_XFER   = 0;
  localparam int unsigned ST_HOSTWR = 1;

  typedef enum logic [1:0] {
    IRQ_NONE = 2'b00, IRQ_CYCLE = 2'b01, IRQ_STALL = 2'b10, IRQ_BUF3 = 2'b11
  } ppm_irq_e;
  typedef enum logic [1:0] {
    STEP_HOLD = 2'b00, STEP_INC = 2'b01, STEP_DEC = 2'b10, STEP_BUF = 2'b11
  } ppm_step_e;
  typedef enum logic [1:0] {
    MODE_LEGACY = 2'b00, MODE_ENH = 2'b01, MODE_MAST2 = 2'b10,
    MODE_MAST1 = 2'b11
  } ppm_mode_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_ADDR = 2'b01, ST_SETUP = 2'b10, ST_STRB = 2'b11
  } ppm_state_e;

  // Mode control register; field order fixes the bit positions.
  typedef struct packed {
    logic       busy;
    ppm_irq_e   irq_request_mode;
    ppm_step_e  addr_step_mode;
    logic       wide_data_select;
    ppm_mode_e  port_mode_select;
    logic [1:0] addr_setup_wait;
    logic [3:0] strobe_wait;
    logic [1:0] data_setup_wait;
  } ppm_ctrl_s;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [REG_AW-1:0] addr;
    logic [15:0]       wdata;
  } ppm_req_s;

  typedef struct packed {
    logic            chip_select;
    logic            read_strobe;
    logic            write_strobe;
    logic            byte_enable;
    logic [PA_W-1:0] address;
    logic            address_oe;
    logic [7:0]      data;
    logic            data_oe;
  } ppm_pin_s;

  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [1:0] a;
    logic [7:0] d;
  } ppm_hsync_s;

endpackage

// >>> ppm_port_ctrl.sv
// Parallel port mode control: register file, master sequencer, slave port.
// Assumes host pins are asynchronous and pass a two-stage synchroniser.
`timescale 1ns/100ps
module ppm_port_ctrl #(
  parameter int unsigned TCY_CLKS = ppm_pkg::CYC_PER_TCY
) (
  input  wire logic             clock_i,
  input  wire logic             arst_n_i,
  input  wire ppm_pkg::ppm_req_s req_i,
  output logic [15:0]           rdata_o,
  input  wire logic             host_cs_i,
  input  wire logic             host_rd_i,
  input  wire logic             host_wr_i,
  input  wire logic [1:0]       addr_i,
  input  wire logic [7:0]       data_i,
  output ppm_pkg::ppm_pin_s     pin_o,
  output logic                  stall_o,
  output logic                  irq_o
);
  import ppm_pkg::*;

  ppm_ctrl_s       ctrl;
  logic [PA_W-1:0] port_addr;
  logic [15:0]     wdata_q;
  logic [15:0]     rdata_q;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  ppm_state_e      state;
  logic [3:0]      cnt;
  logic            second;
  logic            dir_rd;
  logic [7:0]      div;
  ppm_hsync_s      sync1;
  ppm_hsync_s      sync2;
  logic            rd_act_q;
  logic            wr_act_q;
  logic [7:0]      d_last;
  logic [1:0]      leg_ptr;
  logic [7:0]      in_buf  [4];
  logic [7:0]      out_buf [4];
  ppm_pin_s        next_pin;
  logic [15:0]     next_rdata;

  // Selects one of the four slave buffer registers: {hit, index}.
  function automatic logic [2:0] sbuf_sel(input logic [REG_AW-1:0] a);
    logic [REG_AW-1:0] d;
    d = a - OFS_SBUF0;
    sbuf_sel = {(a >= OFS_SBUF0) && (a <= OFS_SBUF3) && (d[1:0] == 2'h0),
                d[3:2]};
  endfunction

  // Next port address after a completed cycle.
  function automatic logic [PA_W-1:0] step_addr(input logic [PA_W-1:0] a,
                                                 input ppm_step_e m);
    case (m)
      STEP_INC: step_addr = a + 11'h001;
      STEP_DEC: step_addr = a - 11'h001;
      default:  step_addr = a;
    endcase
  endfunction

  // Register decode.
  wire [2:0] sb_w     = sbuf_sel(req_i.addr);
  wire wr_ctrl        = req_i.wr && (req_i.addr == OFS_CTRL);
  wire wr_addr        = req_i.wr && (req_i.addr == OFS_ADDR);
  wire wr_data        = req_i.wr && (req_i.addr == OFS_DATA);
  wire wr_mask        = req_i.wr && (req_i.addr == OFS_MASK);
  wire wr_sbuf        = req_i.wr && sb_w[2];
  wire rd_data        = req_i.rd && (req_i.addr == OFS_DATA);
  wire rd_stat        = req_i.rd && (req_i.addr == OFS_STAT);
  wire is_master      = ctrl.port_mode_select[1];

  // Instruction cycle tick from the divider.
  wire instruction_cycle            = (div == 8'(TCY_CLKS - 1));

  // Sequencer decode; data accesses during a transfer are ignored.
  wire busy           = (state != ST_IDLE);
  wire start          = is_master && !busy && (wr_data || rd_data);
  wire [3:0] dsw      = {2'h0, ctrl.data_setup_wait};
  wire phase_end      = instruction_cycle && (((state == ST_ADDR || state == ST_SETUP)
                        && cnt == dsw) ||
                        (state == ST_STRB && cnt == ctrl.strobe_wait));
  wire cycle_done     = phase_end && (state == ST_STRB);
  wire more           = ctrl.wide_data_select && !second;

  // Slave side decode on the second synchroniser stage only.
  wire rd_act         = sync2.cs && sync2.rd;
  wire wr_act         = sync2.cs && sync2.wr;
  wire rd_end         = !is_master && rd_act_q && !rd_act;
  wire wr_end         = !is_master && wr_act_q && !wr_act;
  wire slave_end      = rd_end || wr_end;
  wire is_enh         = (ctrl.port_mode_select == MODE_ENH);
  wire [1:0] cur_idx  = is_enh ? sync2.a : leg_ptr;

  // Interrupt sources; stall and none modes never set the transfer flag.
  wire ev_cycle       = cycle_done || slave_end;
  wire ev_xfer        =
    ((ctrl.irq_request_mode == IRQ_CYCLE) && ev_cycle) ||
    ((ctrl.irq_request_mode == IRQ_BUF3) && slave_end &&
     (cur_idx == LAST_BUF));
  wire [ST_W-1:0] ev  = {wr_end, ev_xfer};

  // Stall the processor for the whole transfer instead of interrupting.
  assign stall_o = busy && (ctrl.irq_request_mode == IRQ_STALL);
  assign irq_o   = |(status & mask);

  // Instruction cycle divider.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div <= 8'h00;
    end else begin
      div <= instruction_cycle ? 8'h00 : div + 8'h01;
    end
  end

  // Control, address and mask registers.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl      <= CTRL_RST;
      port_addr <= 11'h000;
      mask      <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl      <= req_i.wdata;
        ctrl.busy <= 1'b0;
      end
      if (wr_mask) begin
        mask <= req_i.wdata[ST_W-1:0];
      end
      if (wr_addr) begin
        port_addr <= req_i.wdata[PA_W-1:0];
      end else if (cycle_done) begin
        port_addr <= step_addr(port_addr, ctrl.addr_step_mode);
      end
    end
  end

  // Sticky status; a read clears it but a same-cycle event survives.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status <= 2'h0;
    end else begin
      status <= (rd_stat ? 2'h0 : status) | ev;
    end
  end

  // Master sequencer: address phase, data setup, then the strobe.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state  <= ST_IDLE;
      cnt    <= 4'h0;
      second <= 1'b0;
      dir_rd <= 1'b0;
    end else if (start) begin
      state  <= ST_ADDR;
      cnt    <= 4'h0;
      second <= 1'b0;
      dir_rd <= rd_data;
    end else if (phase_end) begin
      cnt <= 4'h0;
      case (state)
        ST_ADDR:  state <= ST_SETUP;
        ST_SETUP: state <= ST_STRB;
        ST_STRB: begin
          state  <= more ? ST_ADDR : ST_IDLE;
          second <= more;
        end
        default:  state <= ST_IDLE;
      endcase
    end else if (busy && instruction_cycle) begin
      cnt <= cnt + 4'h1;
    end
  end

  // Data holding registers; bytes go low first, then high.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
    end else begin
      if (start && wr_data) begin
        wdata_q <= req_i.wdata;
      end
      if (cycle_done && dir_rd) begin
        if (second) begin
          rdata_q[15:8] <= sync2.d;
        end else begin
          rdata_q <= {8'h00, sync2.d};
        end
      end
    end
  end

  // Host pin synchroniser; the first stage feeds only the second.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {host_cs_i, host_rd_i, host_wr_i, addr_i, data_i};
      sync2 <= sync1;
    end
  end

  // Slave access tracking and the legacy buffer pointer.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      d_last   <= 8'h00;
      leg_ptr  <= 2'h0;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      if (wr_act) begin
        d_last <= sync2.d;
      end
      if (is_enh || ctrl.addr_step_mode != STEP_BUF) begin
        leg_ptr <= 2'h0;
      end else if (slave_end) begin
        leg_ptr <= leg_ptr + 2'h1;
      end
    end
  end

  // Slave buffers; the last byte seen during the write strobe is kept.
  always_ff @(posedge clock_i) begin
    if (wr_end) begin
      in_buf[cur_idx] <= d_last;
    end
    if (wr_sbuf) begin
      out_buf[sb_w[1:0]] <= req_i.wdata[7:0];
    end
  end

  // Pin values; a multiplexed address byte leads each master cycle.
  always_comb begin
    next_pin = '0;
    if (is_master) begin
      next_pin.chip_select = busy;
      next_pin.address     = port_addr;
      next_pin.address_oe  = 1'b1;
      if (state == ST_ADDR) begin
        next_pin.data    = port_addr[7:0];
        next_pin.data_oe = 1'b1;
      end else if (busy && !dir_rd) begin
        next_pin.data    = second ? wdata_q[15:8] : wdata_q[7:0];
        next_pin.data_oe = 1'b1;
      end
      if (ctrl.port_mode_select == MODE_MAST1) begin
        next_pin.read_strobe  = busy && dir_rd;
        next_pin.write_strobe = state == ST_STRB;
        next_pin.byte_enable  = busy && ctrl.wide_data_select;
      end else begin
        next_pin.read_strobe  = (state == ST_STRB) && dir_rd;
        next_pin.write_strobe = (state == ST_STRB) && !dir_rd;
      end
    end else begin
      next_pin.data    = rd_act ? out_buf[cur_idx] : 8'h00;
      next_pin.data_oe = rd_act;
    end
  end

  // Register read data, present only in the cycle after the strobe.
  wire [2:0] sb_r = sbuf_sel(req_i.addr);
  always_comb begin
    next_rdata = 16'h0000;
    if (req_i.rd) begin
      case (req_i.addr)
        OFS_CTRL: begin
          next_rdata    = ctrl;
          next_rdata[15] = busy && is_master;
        end
        OFS_ADDR: next_rdata = {5'h00, port_addr};
        OFS_DATA: next_rdata = rdata_q;
        OFS_STAT: next_rdata = {14'h0000, status};
        OFS_MASK: next_rdata = {14'h0000, mask};
        default:  next_rdata = sb_r[2] ? {8'h00, in_buf[sb_r[1:0]]} : 16'h0000;
      endcase
    end
  end

  // Output registers.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_o   <= '0;
      rdata_o <= 16'h0000;
    end else begin
      pin_o   <= next_pin;
      rdata_o <= next_rdata;
    end
  end

  // Helper: instruction cycles spent in the strobe phase.
  logic [4:0] strb_ticks;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strb_ticks <= 5'h00;
    end else if (state != ST_STRB) begin
      strb_ticks <= 5'h00;
    end else if (instruction_cycle) begin
      strb_ticks <= strb_ticks + 5'h01;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  a_busy_flag: assert property (
    req_i.rd && req_i.addr == OFS_CTRL && is_master |=>
      rdata_o[15] == $past(busy))
    else $error("busy flag does not match transfer state");
  a_buf3_irq: assert property (
    ctrl.irq_request_mode == IRQ_BUF3 && slave_end && cur_idx == LAST_BUF
      |=> status[ST_XFER])
    else $error("buffer 3 access did not raise the flag");
  a_stall_quiet: assert property (
    ctrl.irq_request_mode == IRQ_STALL && !rd_stat && !wr_ctrl |=>
      status[ST_XFER] == $past(status[ST_XFER]) && (busy == stall_o))
    else $error("stall mode raised a flag or dropped the stall");
  a_cycle_irq: assert property (
    ctrl.irq_request_mode == IRQ_CYCLE && cycle_done |=> status[ST_XFER])
    else $error("completed cycle did not raise the flag");
  a_leg_step: assert property (
    !is_enh && ctrl.addr_step_mode == STEP_BUF && slave_end && !wr_ctrl
      |=> leg_ptr == $past(leg_ptr) + 2'h1)
    else $error("legacy buffer pointer did not advance");
  a_addr_step: assert property (
    cycle_done && !wr_addr && ctrl.addr_step_mode == STEP_DEC |=>
      port_addr == $past(port_addr) - 11'h001)
    else $error("port address did not decrement");
  a_addr_hold: assert property (
    !wr_addr && ctrl.addr_step_mode == STEP_HOLD |=>
      port_addr == $past(port_addr))
    else $error("port address changed in hold mode");
  a_wide_two: assert property (
    cycle_done && ctrl.wide_data_select && !second |=>
      state == ST_ADDR && second)
    else $error("wide access did not start its second byte");
  a_narrow_one: assert property (
    cycle_done && !ctrl.wide_data_select |=> state == ST_IDLE)
    else $error("narrow access ran a second transfer");
  a_slave_drive: assert property (
    !is_master && !rd_act |=> !pin_o.data_oe)
    else $error("slave drove data without a host read");
  a_mast1_pins: assert property (
    ctrl.port_mode_select == MODE_MAST1 && state == ST_STRB |=>
      pin_o.write_strobe && pin_o.chip_select && pin_o.address_oe)
    else $error("master mode 1 strobe pins wrong");
  a_addr_phase: assert property (
    $rose(state == ST_ADDR) && ctrl.data_setup_wait == 2'h0 && instruction_cycle |=>
      state == ST_SETUP)
    else $error("shortest address phase exceeded one cycle");
  a_mast2_read: assert property (
    ctrl.port_mode_select == MODE_MAST2 && state == ST_STRB && dir_rd
      |=> pin_o.read_strobe && !pin_o.write_strobe)
    else $error("master mode 2 read strobe wrong");
  a_enh_buffer: assert property (
    is_enh && wr_end |=> in_buf[$past(cur_idx)] == $past(d_last))
    else $error("enhanced slave write missed its buffer");
  a_strobe_len: assert property (
    $fell(state == ST_STRB) |->
      strb_ticks == {1'b0, $past(ctrl.strobe_wait)} + 5'h01)
    else $error("strobe length differs from the wait setting");
  a_step_after: assert property (
    busy && !cycle_done && !wr_addr |=> port_addr == $past(port_addr))
    else $error("address moved before the cycle completed");

  c_wide_write: cover property (cycle_done && second && !dir_rd);
  c_buf3_irq: cover property (slave_end && cur_idx == LAST_BUF ##1 irq_o);
  c_stall: cover property (stall_o ##1 !stall_o);
  c_dec_step: cover property (cycle_done &&
                              ctrl.addr_step_mode == STEP_DEC);
endmodule

// >>> ppm_far_model.sv
// Far-side model: a byte memory that answers the master pins, and a host
// that drives the slave strobes. Assumes the shared pin struct.
`timescale 1ns/100ps
module ppm_far_model (
  input  wire logic              clock_i,
  input  wire logic              arst_n_i,
  input  wire ppm_pkg::ppm_pin_s pin_i,
  output logic [7:0]             data_o,
  output logic                   host_cs_o,
  output logic                   host_rd_o,
  output logic                   host_wr_o,
  output logic [1:0]             host_a_o
);
  import ppm_pkg::*;
  logic [7:0]  mem [0:2047];
  logic [7:0]  host_d;
  logic [7:0]  last_d;
  logic [7:0]  wr_byte;
  logic [10:0] wr_addr;
  logic        host_drv;
  logic        wr_q;
  int          wr_cnt;
  wire logic   rd_act = pin_i.chip_select & pin_i.read_strobe;
  // The first master mode holds the read line as a direction level for the
  // whole transfer, so a write needs it low as well as the strobe high.
  wire logic   wr_act = pin_i.chip_select & pin_i.write_strobe &
                        ~pin_i.read_strobe;

  // A known pattern lets the bench predict every master read.
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    {host_cs_o, host_rd_o, host_wr_o, host_drv} = 4'h0;
    {host_a_o, host_d, last_d, wr_q} = '0;
    wr_cnt = 0;
  end

  // Released lines show the inverse of the last value, never a stale byte.
  assign data_o = host_drv ? host_d : rd_act ? mem[pin_i.address] : ~last_d;

  // A write lands when the strobe ends; each landing is one bus transfer.
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_q <= 1'b0;
    end else begin
      last_d <= data_o;
      wr_q   <= wr_act;
      if (wr_act) begin
        wr_byte <= pin_i.data;
        wr_addr <= pin_i.address;
      end
      if (wr_q && !wr_act) begin
        mem[wr_addr] <= wr_byte;
        wr_cnt       <= wr_cnt + 1;
      end
    end
  end

  // Host write strobes stay four clocks high so the synchroniser sees them.
  task automatic host_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock_i);
    host_a_o  <= a;
    host_d    <= d;
    host_drv  <= 1'b1;
    host_cs_o <= 1'b1;
    host_wr_o <= 1'b1;
    repeat (4) @(posedge clock_i);
    host_cs_o <= 1'b0;
    host_wr_o <= 1'b0;
    @(posedge clock_i);
    host_drv <= 1'b0;
    repeat (6) @(posedge clock_i);
  endtask

  // The byte is taken late in the strobe, after the device has answered.
  task automatic host_read(input logic [1:0] a, output logic [8:0] d);
    @(posedge clock_i);
    host_a_o  <= a;
    host_cs_o <= 1'b1;
    host_rd_o <= 1'b1;
    repeat (6) @(posedge clock_i);
    @(negedge clock_i);
    d = {pin_i.data_oe, pin_i.data};
    @(posedge clock_i);
    host_cs_o <= 1'b0;
    host_rd_o <= 1'b0;
    repeat (6) @(posedge clock_i);
  endtask
endmodule

// >>> tb_parallel_port_mode_control.sv
// Self-checking bench for the parallel port mode control block.
// Assumes the package and the far-side model are compiled first.
`timescale 1ns/100ps
module tb_parallel_port_mode_control;
  import ppm_pkg::*;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [10:0] a;
    logic        wr;
    logic [7:0]  wd;
  } ppm_row_s;
  logic        clock_i    = 1'b0;
  logic        arst_n_i   = 1'b0;
  ppm_req_s    req_i      = '0;
  logic        stall_seen = 1'b0;
  logic [15:0] rdata_o;
  ppm_pin_s    pin_o;
  logic        stall_o;
  logic        irq_o;
  logic        h_cs;
  logic        h_rd;
  logic        h_wr;
  logic [1:0]  h_a;
  logic [7:0]  h_d;
  logic [15:0] d;
  logic [10:0] ea;
  logic [8:0]  hb;
  int          fail_count = 0;
  int          n_tests    = 0;
  int          cyc        = 0;
  int          n0;
  // Master rows: control word, start address, write or read, data byte.
  ppm_row_s    rows [0:6] = '{
    '{16'h2A05, 11'h7FF, 1'b1, 8'hC3}, '{16'h133C, 11'h000, 1'b1, 8'h3C},
    '{16'h0203, 11'h123, 1'b1, 8'h96}, '{16'h4200, 11'h0A0, 1'b1, 8'h11},
    '{16'h2A0C, 11'h200, 1'b0, 8'h00}, '{16'h130C, 11'h300, 1'b0, 8'h00},
    '{16'h2B00, 11'h055, 1'b1, 8'h5E}};

  ppm_port_ctrl #(.TCY_CLKS(2)) uut (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .req_i(req_i),
    .rdata_o(rdata_o), .host_cs_i(h_cs), .host_rd_i(h_rd),
    .host_wr_i(h_wr), .addr_i(h_a), .data_i(h_d), .pin_o(pin_o),
    .stall_o(stall_o), .irq_o(irq_o));
  ppm_far_model far (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .pin_i(pin_o), .data_o(h_d),
    .host_cs_o(h_cs), .host_rd_o(h_rd), .host_wr_o(h_wr), .host_a_o(h_a));

  // Clock, hang limit and a stall watcher sampled away from the edge.
  always #2.5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      wrap_up();
    end
  end
  always @(negedge clock_i) begin
    if (stall_o === 1'b1) stall_seen = 1'b1;
  end

  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic reg_wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge clock_i);
    req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clock_i);
    req_i <= '0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic reg_rd(input logic [5:0] a, output logic [15:0] v);
    @(posedge clock_i);
    req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clock_i);
    req_i <= '0;
    @(negedge clock_i);
    v = rdata_o;
  endtask
  task automatic wait_idle();
    logic [15:0] v;
    int          k;
    v = 16'h8000;
    k = 0;
    while (v[15] !== 1'b0 && k < 300) begin
      reg_rd(OFS_CTRL, v);
      k++;
    end
    if (k == 300) chk("idle", 32'h0, 32'(v));
    // The far side lands a write two clocks after busy drops, so settle.
    repeat (2) @(negedge clock_i);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clock_i);
    arst_n_i <= 1'b1;
    @(negedge clock_i);
    chk("outs_rst", 32'h0, {rdata_o, stall_o, irq_o, pin_o[13:0]});
    reg_rd(OFS_CTRL, d);
    chk("ctrl_rst", 32'(CTRL_RST), 32'(d));
    reg_wr(OFS_CTRL, 16'hFFFF);
    reg_rd(OFS_CTRL, d);
    chk("ctrl_ro", 32'h7FFF, 32'(d));
    reg_wr(OFS_ADDR, 16'hFFFF);
    reg_rd(OFS_ADDR, d);
    chk("addr_w", 32'h07FF, 32'(d));
    reg_wr(6'h3C, 16'hABCD);
    reg_rd(6'h3C, d);
    chk("unmapped", 32'h0, 32'(d));
    reg_wr(OFS_MASK, 16'h0000);
    // Narrow master transfers, with interrupts masked throughout.
    foreach (rows[i]) begin
      reg_wr(OFS_CTRL, rows[i].ctrl);
      reg_wr(OFS_ADDR, 16'(rows[i].a));
      n0 = far.wr_cnt;
      stall_seen = 1'b0;
      if (rows[i].wr) reg_wr(OFS_DATA, 16'(rows[i].wd));
      else reg_rd(OFS_DATA, d);
      reg_rd(OFS_CTRL, d);
      if (rows[i].ctrl[14:13] != 2'b10) chk("busy", 32'h1, 32'(d[15]));
      wait_idle();
      chk("stall", 32'(rows[i].ctrl[14:13] == 2'b10), 32'(stall_seen));
      ea = rows[i].a;
      if (rows[i].ctrl[12:11] == 2'b01) ea = rows[i].a + 11'h1;
      if (rows[i].ctrl[12:11] == 2'b10) ea = rows[i].a - 11'h1;
      reg_rd(OFS_ADDR, d);
      chk("step", 32'(ea), 32'(d));
      if (rows[i].wr) begin
        chk("mem", 32'(rows[i].wd), 32'(far.mem[rows[i].a]));
        chk("count", 32'h1, 32'(far.wr_cnt - n0));
      end else begin
        reg_rd(OFS_DATA, d);
        chk("rd", 32'(rows[i].a[7:0] ^ 8'h5A), 32'(d));
        wait_idle();
      end
      chk("irq_mask", 32'h0, 32'(irq_o));
      reg_rd(OFS_STAT, d);
      chk("stat", 32'(rows[i].ctrl[14:13] == 2'b01), 32'(d[0]));
    end
    // Wide write then wide read: two transfers each, low byte first.
    reg_wr(OFS_CTRL, 16'h0E00);
    reg_wr(OFS_ADDR, 16'h0010);
    n0 = far.wr_cnt;
    reg_wr(OFS_DATA, 16'hBEEF);
    wait_idle();
    chk("wide_cnt", 32'h2, 32'(far.wr_cnt - n0));
    chk("wide_mem", 32'hBEEF, {far.mem[17], far.mem[16]});
    reg_wr(OFS_CTRL, 16'h0F0C);
    reg_wr(OFS_ADDR, 16'h0020);
    reg_rd(OFS_DATA, d);
    reg_rd(OFS_CTRL, d);
    chk("wide_pins", 32'h3, {pin_o.chip_select, pin_o.byte_enable});
    wait_idle();
    reg_rd(OFS_DATA, d);
    chk("wide_rd", 32'h7B7A, 32'(d));
    wait_idle();
    reg_rd(OFS_ADDR, d);
    chk("wide_step", 32'h0024, 32'(d));
    // Unmasked completion event raises the line; the status read drops it.
    reg_wr(OFS_MASK, 16'h0001);
    reg_wr(OFS_CTRL, 16'h2A00);
    reg_wr(OFS_DATA, 16'h0055);
    wait_idle();
    chk("irq_on", 32'h1, 32'(irq_o));
    reg_rd(OFS_STAT, d);
    @(negedge clock_i);
    chk("irq_off", 32'h2, {d[0], irq_o});
    // Legacy slave: host write, then host read of a loaded buffer.
    reg_wr(OFS_CTRL, 16'h0000);
    far.host_write(2'h0, 8'h3C);
    reg_rd(OFS_SBUF0, d);
    chk("legacy_wr", 32'h003C, 32'(d));
    reg_rd(OFS_STAT, d);
    chk("host_done", 32'h1, 32'(d[1]));
    reg_wr(OFS_SBUF0, 16'h0081);
    far.host_read(2'h0, hb);
    chk("legacy_rd", 32'h181, 32'(hb));
    // Enhanced slave: buffer chosen by the address pins; 3 interrupts.
    reg_wr(OFS_CTRL, 16'h6100);
    far.host_write(2'h3, 8'h77);
    reg_rd(OFS_SBUF3, d);
    chk("enh_b3", 32'h0077, 32'(d));
    reg_rd(OFS_STAT, d);
    chk("enh_irq3", 32'h1, 32'(d[0]));
    far.host_write(2'h1, 8'h22);
    reg_rd(OFS_SBUF0 + 6'h04, d);
    chk("enh_b1", 32'h0022, 32'(d));
    reg_rd(OFS_STAT, d);
    chk("enh_irq1", 32'h0, 32'(d[0]));
    // Legacy auto-advance: four writes fill buffers 0 to 3 in turn.
    reg_wr(OFS_CTRL, 16'h7800);
    for (int i = 0; i < 4; i++) begin
      far.host_write(2'h0, 8'hA0 + 8'(i));
      reg_rd(OFS_STAT, d);
      chk("adv_irq", 32'(i == 3), 32'(d[0]));
    end
    for (int i = 0; i < 4; i++) begin
      reg_rd(OFS_SBUF0 + 6'(4 * i), d);
      chk("adv_buf", 32'hA0 + 32'(i), 32'(d));
    end
    wrap_up();
  end
endmodule
